/* File: cesc_pkg.sv */
// Package with the constants, command codes and state types of the command error status checker.
package cesc_pkg;

    // Register bus geometry: word index on the bus, 32-bit data, 16-bit registers.
    localparam int unsigned CESC_AW    = 2;
    localparam int unsigned CESC_BUS_W = 32;
    localparam int unsigned CESC_REG_W = 16;

    // Register word indexes; byte address is four times the index.
    localparam logic [1:0] CESC_STATUS_IDX = 2'h0;
    localparam logic [1:0] CESC_MASK_IDX   = 2'h1;

    // Positions of the flags in the command error status register.
    localparam int unsigned CESC_BIT_CAPT  = 8;
    localparam int unsigned CESC_BIT_SERVO = 9;
    localparam int unsigned CESC_BIT_AXIS  = 11;
    localparam int unsigned CESC_BIT_COORD = 12;
    localparam int unsigned CESC_BIT_MOVE  = 13;
    localparam int unsigned CESC_BIT_FULL  = 15;

    // Bits that can ever be set; the rest read as zero.
    localparam logic [15:0] CESC_IMPL_MASK = 16'hbb00;

    // Values after reset.
    localparam logic [15:0] CESC_STATUS_RST = 16'h0000;
    localparam logic [15:0] CESC_MASK_RST   = 16'h0000;
    localparam logic [31:0] CESC_RDATA_RST  = 32'h0000_0000;

    // Host command codes as presented on the command port.
    typedef enum logic [3:0] {
        CMD_NOP         = 4'h0,
        CMD_ARM_HOME    = 4'h1,
        CMD_ARM_INDEX   = 4'h2,
        CMD_SERVO_ON    = 4'h3,
        CMD_ZERO_POS    = 4'h4,
        CMD_SYNC_POS    = 4'h5,
        CMD_APPLY_AXIS  = 4'h6,
        CMD_APPLY_MULTI = 4'h7,
        CMD_BUILD_COORD = 4'h8,
        CMD_START_COORD = 4'h9,
        CMD_START_LIST  = 4'ha,
        CMD_APPEND_LIST = 4'hb,
        CMD_MOVE_TWO    = 4'hc,
        CMD_MOVE_THREE  = 4'hd,
        CMD_MOVE_FOUR   = 4'he,
        CMD_MOTION_DESC = 4'hf
    } cesc_cmd_type;

    // Bus slave handshake states, one-hot.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } cesc_bus_state_type;

endpackage

/* File: cesc_if.sv */
// Interfaces joining the top of the checker to its bus slave and its error classifier.
`timescale 1ns/1ps

interface cesc_reg_if;
    import cesc_pkg::*;
    logic                 wr_stb;
    logic [CESC_AW-1:0]   idx;
    logic [15:0]          wdata;
    logic [15:0]          rdata;
    modport slave (output wr_stb, idx, wdata, input rdata);
    modport regs  (input wr_stb, idx, wdata, output rdata);
endinterface

interface cesc_chk_if;
    import cesc_pkg::*;
    cesc_cmd_type code;
    logic         capt_done, capt_armed, drv_alarm, moving, vel_mode, param_locked;
    logic         coord_moving, list_exec, list_input, imm_busy, move_bad, buf_full;
    logic [15:0]  err;
    modport check (input code, capt_done, capt_armed, drv_alarm, moving, vel_mode, param_locked,
                   coord_moving, list_exec, list_input, imm_busy, move_bad, buf_full, output err);
    modport user  (output code, capt_done, capt_armed, drv_alarm, moving, vel_mode, param_locked,
                   coord_moving, list_exec, list_input, imm_busy, move_bad, buf_full, input err);
endinterface

/* File: cesc_classifier.sv */
// Combinational classifier that maps a command and the axis state onto error flags.
`timescale 1ns/1ps

module cesc_classifier
    import cesc_pkg::*;
(
    cesc_chk_if.check chk
);

    logic is_desc;
    logic is_move;

    // Linear moves count as motion description commands for the busy and full checks.
    always_comb begin
        is_move = (chk.code == CMD_MOVE_TWO) || (chk.code == CMD_MOVE_THREE) || (chk.code == CMD_MOVE_FOUR);
        is_desc = is_move || (chk.code == CMD_MOTION_DESC);
        chk.err = '0;
        chk.err[CESC_BIT_CAPT]  = (chk.code == CMD_ARM_HOME) && (chk.capt_done || chk.capt_armed);
        chk.err[CESC_BIT_SERVO] = (chk.code == CMD_SERVO_ON) && chk.drv_alarm;
        chk.err[CESC_BIT_AXIS]  = ((chk.code == CMD_ZERO_POS) && chk.moving)
                               || ((chk.code == CMD_SYNC_POS) && chk.vel_mode)
                               || (((chk.code == CMD_APPLY_AXIS) || (chk.code == CMD_APPLY_MULTI))
                                   && chk.moving && chk.param_locked);
        chk.err[CESC_BIT_COORD] = ((chk.code == CMD_BUILD_COORD) && chk.coord_moving)
                               || (((chk.code == CMD_START_COORD) || (chk.code == CMD_START_LIST))
                                   && chk.list_exec)
                               || ((chk.code == CMD_APPEND_LIST) && chk.list_input)
                               || (is_desc && chk.imm_busy);
        chk.err[CESC_BIT_MOVE]  = is_move && chk.move_bad;
        chk.err[CESC_BIT_FULL]  = is_desc && chk.buf_full;
    end

endmodule

/* File: cesc_avmm_slave.sv */
// Avalon-MM slave front end with one wait state for every access.
`timescale 1ns/1ps

module cesc_avmm_slave
    import cesc_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    input  wire logic                  ce,
    input  wire logic [CESC_AW-1:0]    avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [CESC_BUS_W-1:0] avs_writedata,
    output logic      [CESC_BUS_W-1:0] avs_readdata,
    output logic                       avs_waitrequest,
    cesc_reg_if.slave                  bus
);

    cesc_bus_state_type    state_r;
    cesc_bus_state_type    state_nxt;
    logic                  waitrequest_nxt;
    logic [CESC_BUS_W-1:0] readdata_nxt;

    // The register view is picked from the held address; the write lands on the acknowledge edge.
    assign bus.idx    = avs_address;
    assign bus.wdata  = avs_writedata[15:0];
    assign bus.wr_stb = (state_r == BUS_ACK) && avs_write;

    // Read data is captured one cycle early so that it comes straight from a flip-flop.
    always_comb begin
        state_nxt       = state_r;
        waitrequest_nxt = 1'b1;
        readdata_nxt    = avs_readdata;
        case (state_r)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    state_nxt       = BUS_ACK;
                    waitrequest_nxt = 1'b0;
                    readdata_nxt    = avs_read ? {16'h0000, bus.rdata} : CESC_RDATA_RST;
                end
            end
            BUS_ACK: begin
                state_nxt = BUS_IDLE;
            end
            default: begin
                state_nxt = BUS_IDLE;
            end
        endcase
    end

    // Handshake registers; frozen while the clock enable is low.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_r         <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= CESC_RDATA_RST;
        end else if (ce) begin
            state_r         <= state_nxt;
            avs_waitrequest <= waitrequest_nxt;
            avs_readdata    <= readdata_nxt;
        end
    end

endmodule

/* File: cesc_top.sv */
// Top of the command error status checker: command gate, sticky error register and interrupt.
//
// Overview of operation
// - Arming home capture while a capture is complete or still armed sets bit 8.
// - Enabling the servo while the axis driver alarm is up sets bit 9.
// - Zeroing the axis position while the axis moves sets bit 11.
// - Making a position synchronisation effective in velocity mode sets bit 11.
// - A single or multi-axis parameter update the moving motion mode forbids sets bit 11.
// - Building a coordinate system while a mapped axis moves sets bit 12.
// - Starting coordinated motion or a buffered list while the list still executes sets bit 12.
// - Appending to the list while list input is in progress sets bit 12.
// - A motion description command during an unfinished immediate motion sets bit 12.
// - An erroneous two, three or four axis linear move sets bit 13.
// - A motion description command while the buffer is full sets bit 15 and is not taken.
// - The command error status register can be read at any time.
// - The command error status register is 16 bits; bits 8, 9, 11, 12, 13 and 15 each hold one error class, the rest read zero.
// - A command found in error is dropped and never reaches the axis logic.
`timescale 1ns/1ps

module cesc_top
    import cesc_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    input  wire logic                  ce,
    input  wire logic [CESC_AW-1:0]    avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [CESC_BUS_W-1:0] avs_writedata,
    output logic      [CESC_BUS_W-1:0] avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic                  cmd_valid,
    input  wire cesc_cmd_type          cmd_code,
    input  wire logic                  capt_done,
    input  wire logic                  capt_armed,
    input  wire logic                  drv_alarm,
    input  wire logic                  axis_moving,
    input  wire logic                  vel_mode,
    input  wire logic                  param_locked,
    input  wire logic                  coord_moving,
    input  wire logic                  list_exec,
    input  wire logic                  list_input,
    input  wire logic                  imm_busy,
    input  wire logic                  move_bad,
    input  wire logic                  buf_full,
    output logic                       cmd_done,
    output logic                       cmd_accepted,
    output logic                       exec_valid,
    output cesc_cmd_type               exec_code,
    output logic                       irq
);

    cesc_reg_if bus ();
    cesc_chk_if chk ();

    logic [15:0]  status_r;
    logic [15:0]  status_nxt;
    logic [15:0]  mask_r;
    logic [15:0]  mask_nxt;
    logic [15:0]  set_vec;
    logic [15:0]  clr_vec;
    logic         irq_nxt;
    logic         done_nxt;
    logic         accepted_nxt;
    logic         exec_valid_nxt;
    cesc_cmd_type exec_code_nxt;

    // Bus front end; every access is answered after one wait state.
    cesc_avmm_slave u_slave (
        .core_clk        (core_clk),
        .nrst            (nrst),
        .ce              (ce),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .bus             (bus.slave)
    );

    // Error classifier sees the command code together with the axis and buffer state.
    cesc_classifier u_classifier (
        .chk (chk.check)
    );

    // Present the command and the state snapshot to the classifier.
    assign chk.code         = cmd_code;
    assign chk.capt_done    = capt_done;
    assign chk.capt_armed   = capt_armed;
    assign chk.drv_alarm    = drv_alarm;
    assign chk.moving       = axis_moving;
    assign chk.vel_mode     = vel_mode;
    assign chk.param_locked = param_locked;
    assign chk.coord_moving = coord_moving;
    assign chk.list_exec    = list_exec;
    assign chk.list_input   = list_input;
    assign chk.imm_busy     = imm_busy;
    assign chk.move_bad     = move_bad;
    assign chk.buf_full     = buf_full;

    // Flags raised this cycle and flags software clears by writing ones to the status word.
    assign set_vec = cmd_valid ? (chk.err & CESC_IMPL_MASK) : 16'h0000;
    assign clr_vec = (bus.wr_stb && (bus.idx == CESC_STATUS_IDX)) ? bus.wdata : 16'h0000;

    // Sticky flags: a set in the same cycle as its clear wins, so no error is lost.
    // Unused positions are held at zero so that a read never shows a stale value there.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_flag
            assign status_nxt[gi] = CESC_IMPL_MASK[gi] & (set_vec[gi] | (status_r[gi] & ~clr_vec[gi]));
        end
    endgenerate

    // Readback of the register view; unmapped words read as zero and ignore writes.
    always_comb begin
        case (bus.idx)
            CESC_STATUS_IDX: bus.rdata = status_r;
            CESC_MASK_IDX:   bus.rdata = mask_r;
            default:         bus.rdata = 16'h0000;
        endcase
    end

    // Mask register and the level interrupt derived from the next flag state.
    always_comb begin
        mask_nxt = mask_r;
        if (bus.wr_stb && (bus.idx == CESC_MASK_IDX)) begin
            mask_nxt = bus.wdata & CESC_IMPL_MASK;
        end
        irq_nxt = |(status_nxt & mask_nxt);
    end

    // Command gate: an erroneous command is answered but never forwarded to the axis logic.
    always_comb begin
        done_nxt       = cmd_valid;
        accepted_nxt   = cmd_valid && (set_vec == 16'h0000);
        exec_valid_nxt = accepted_nxt;
        exec_code_nxt  = accepted_nxt ? cmd_code : CMD_NOP;
    end

    // State registers; the clock enable freezes everything, including the answer strobes.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            status_r     <= CESC_STATUS_RST;
            mask_r       <= CESC_MASK_RST;
            irq          <= 1'b0;
            cmd_done     <= 1'b0;
            cmd_accepted <= 1'b0;
            exec_valid   <= 1'b0;
            exec_code    <= CMD_NOP;
        end else if (ce) begin
            status_r     <= status_nxt;
            mask_r       <= mask_nxt;
            irq          <= irq_nxt;
            cmd_done     <= done_nxt;
            cmd_accepted <= accepted_nxt;
            exec_valid   <= exec_valid_nxt;
            exec_code    <= exec_code_nxt;
        end
    end

    // Checks of the error classification, command gate and register access.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    a_capt_home_flag: assert property (
        (ce && cmd_valid && cmd_code == CMD_ARM_HOME && (capt_done || capt_armed))
        |=> (status_r[CESC_BIT_CAPT] && !exec_valid && cmd_done))
        else $error("Home capture conflict did not raise bit 8.");

    a_servo_alarm_flag: assert property (
        (ce && cmd_valid && cmd_code == CMD_SERVO_ON && drv_alarm)
        |=> (status_r[CESC_BIT_SERVO] && !cmd_accepted))
        else $error("Servo enable under alarm did not raise bit 9.");

    a_zero_moving_flag: assert property (
        (ce && cmd_valid && cmd_code == CMD_ZERO_POS && axis_moving)
        |=> status_r[CESC_BIT_AXIS])
        else $error("Zeroing a moving axis did not raise bit 11.");

    a_sync_vel_flag: assert property (
        (ce && cmd_valid && cmd_code == CMD_SYNC_POS && vel_mode)
        |=> (status_r[CESC_BIT_AXIS] && !exec_valid))
        else $error("Sync in velocity mode did not raise bit 11.");

    a_param_lock_flag: assert property (
        (ce && cmd_valid && (cmd_code == CMD_APPLY_AXIS || cmd_code == CMD_APPLY_MULTI)
         && axis_moving && param_locked)
        |=> status_r[CESC_BIT_AXIS])
        else $error("Forbidden parameter update did not raise bit 11.");

    a_param_free_pass: assert property (
        (ce && cmd_valid && cmd_code == CMD_APPLY_AXIS && !param_locked)
        |=> (cmd_accepted && exec_valid && exec_code == CMD_APPLY_AXIS))
        else $error("Permitted parameter update was refused.");

    a_coord_build_flag: assert property (
        (ce && cmd_valid && cmd_code == CMD_BUILD_COORD && coord_moving)
        |=> status_r[CESC_BIT_COORD])
        else $error("Coordinate build on a moving axis did not raise bit 12.");

    a_list_start_flag: assert property (
        (ce && cmd_valid && (cmd_code == CMD_START_COORD || cmd_code == CMD_START_LIST) && list_exec)
        |=> status_r[CESC_BIT_COORD])
        else $error("Start during list execution did not raise bit 12.");

    a_append_busy_flag: assert property (
        (ce && cmd_valid && cmd_code == CMD_APPEND_LIST && list_input)
        |=> status_r[CESC_BIT_COORD])
        else $error("Append during list input did not raise bit 12.");

    a_imm_busy_flag: assert property (
        (ce && cmd_valid && cmd_code == CMD_MOTION_DESC && imm_busy)
        |=> (status_r[CESC_BIT_COORD] && !exec_valid))
        else $error("Motion command during immediate motion did not raise bit 12.");

    a_move_err_flag: assert property (
        (ce && cmd_valid && (cmd_code == CMD_MOVE_TWO || cmd_code == CMD_MOVE_THREE
                             || cmd_code == CMD_MOVE_FOUR) && move_bad)
        |=> status_r[CESC_BIT_MOVE])
        else $error("Bad linear move did not raise bit 13.");

    a_full_reject: assert property (
        (ce && cmd_valid && cmd_code == CMD_MOTION_DESC && buf_full)
        |=> (status_r[CESC_BIT_FULL] && cmd_done && !cmd_accepted && !exec_valid))
        else $error("Command taken while the buffer was full.");

    a_retry_taken: assert property (
        (ce && cmd_valid && cmd_code == CMD_MOTION_DESC && !buf_full && !imm_busy)
        |=> (exec_valid && exec_code == CMD_MOTION_DESC))
        else $error("Resent motion command not taken once room was free.");

    a_read_any_time: assert property (
        (ce && avs_read && avs_waitrequest) ##1 ce |-> !avs_waitrequest ##1 avs_waitrequest)
        else $error("Read was not answered after one wait state.");

    a_read_value: assert property (
        (ce && avs_read && avs_waitrequest && avs_address == CESC_STATUS_IDX)
        |=> (avs_readdata == {16'h0000, $past(status_r)}))
        else $error("Status read returned the wrong word.");

    a_error_dropped: assert property (
        (ce && cmd_valid && (chk.err != 16'h0000)) |=> (!exec_valid && exec_code == CMD_NOP))
        else $error("Erroneous command reached the axis logic.");

    a_blank_bits_zero: assert property (
        (status_r[10] == 1'b0) && (status_r[14] == 1'b0) && (avs_readdata[31:16] == 16'h0000))
        else $error("Unused status bits read non-zero.");

    a_sticky_hold: assert property (
        (ce && !cmd_valid && !(bus.wr_stb && bus.idx == CESC_STATUS_IDX)) |=> $stable(status_r))
        else $error("Status flag changed with no cause.");

    a_freeze_hold: assert property (
        !ce |=> ($stable(status_r) && $stable(cmd_done) && $stable(avs_waitrequest)))
        else $error("State moved while the clock enable was low.");

    a_irq_follows: assert property (
        ##1 (irq == |(status_r & mask_r)))
        else $error("Interrupt does not follow the unmasked flags.");

    c_full_reject: cover property (
        ce && cmd_valid && buf_full && cmd_code == CMD_MOTION_DESC ##1 ce && cmd_valid && !buf_full);
    c_flag_cleared: cover property (
        status_r[CESC_BIT_AXIS] ##[1:8] !status_r[CESC_BIT_AXIS]);
    c_irq_raised: cover property (
        !irq ##1 irq);
    c_set_wins: cover property (
        ce && set_vec[CESC_BIT_COORD] && clr_vec[CESC_BIT_COORD]);

endmodule

/* File: cesc_host_model.sv */
// Host-side model that issues commands and resends those refused for a full buffer.
`timescale 1ns/1ps

module cesc_host_model
    import cesc_pkg::*;
(
    input  wire logic    core_clk,
    input  wire logic    cmd_accepted,
    output logic         cmd_valid,
    output cesc_cmd_type cmd_code
);
    // The command port is idle from time zero.
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = CMD_NOP;
    end

    // One command per edge; called just after a rising edge so calls may follow back to back.
    task automatic send(input cesc_cmd_type code);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        @(posedge core_clk);
    endtask

    // Lowers the request so a held code is not taken as a further command.
    task automatic stop();
        cmd_valid <= 1'b0;
        cmd_code  <= CMD_NOP;
    endtask

    // Offers the command every second cycle until taken; the cap keeps a stuck device from hanging us.
    task automatic resend(input cesc_cmd_type code, output int tries);
        bit taken;
        taken = 1'b0;
        tries = 0;
        while (!taken && tries < 8) begin
            send(code);
            stop();
            tries++;
            @(negedge core_clk);
            taken = (cmd_accepted === 1'b1);
            @(posedge core_clk);
        end
    endtask
endmodule

/* File: tb_command_error_status_checker.sv */
// Self-checking bench for the command error status checker: commands, register bus and interrupt.
`timescale 1ns/1ps

module tb_command_error_status_checker;
    import cesc_pkg::*;

    logic                  core_clk      = 1'b0;
    logic                  nrst          = 1'b0;
    logic [CESC_AW-1:0]    avs_address   = '0;
    logic                  avs_read      = 1'b0;
    logic                  ce            = 1'b1;
    logic                  avs_write     = 1'b0;
    logic [CESC_BUS_W-1:0] avs_writedata = '0;
    logic [CESC_BUS_W-1:0] avs_readdata;
    logic                  avs_waitrequest, cmd_valid, cmd_done, cmd_accepted, exec_valid, irq;
    cesc_cmd_type          cmd_code, exec_code;
    logic [11:0]           st            = 12'h000;
    logic [15:0]           st_m          = 16'h0000;
    logic [15:0]           mask_m        = 16'h0000;
    logic [5:0]            cmd_q[$];
    logic [31:0]           rd_q[$];
    int                    error_cnt     = 0;
    int                    checks_done   = 0;
    int                    cyc           = 0;
    integer                seed          = 32'hdad0_ef0d;

    always #25 core_clk = ~core_clk;

    cesc_top uut (.core_clk(core_clk), .nrst(nrst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .capt_done(st[0]), .capt_armed(st[1]), .drv_alarm(st[2]),
        .axis_moving(st[3]), .vel_mode(st[4]), .param_locked(st[5]), .coord_moving(st[6]),
        .list_exec(st[7]), .list_input(st[8]), .imm_busy(st[9]), .move_bad(st[10]),
        .buf_full(st[11]), .cmd_done(cmd_done), .cmd_accepted(cmd_accepted),
        .exec_valid(exec_valid), .exec_code(exec_code), .irq(irq));

    cesc_host_model host (.core_clk(core_clk), .cmd_accepted(cmd_accepted), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code));

    // Error flags the device must raise for a command seen with the given axis state.
    function automatic logic [15:0] exp_err(input cesc_cmd_type c, input logic [11:0] s);
        logic        desc;
        logic [15:0] e;
        desc  = (c >= CMD_MOVE_TWO);
        e     = 16'h0000;
        e[8]  = (c == CMD_ARM_HOME) && (s[0] || s[1]);
        e[9]  = (c == CMD_SERVO_ON) && s[2];
        e[11] = ((c == CMD_ZERO_POS) && s[3]) || ((c == CMD_SYNC_POS) && s[4])
              || ((c == CMD_APPLY_AXIS || c == CMD_APPLY_MULTI) && s[3] && s[5]);
        e[12] = ((c == CMD_BUILD_COORD) && s[6]) || ((c == CMD_START_COORD || c == CMD_START_LIST) && s[7])
              || ((c == CMD_APPEND_LIST) && s[8]) || (desc && s[9]);
        e[13] = desc && (c != CMD_MOTION_DESC) && s[10];
        e[15] = desc && s[11];
        return e;
    endfunction

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cmd(input logic [5:0] got, input logic [5:0] exp);
        chk_word({26'h0, got}, {26'h0, exp});
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Holds the request until waitrequest is seen low; one idle edge follows so strobes never toggle twice.
    task automatic bus(input logic wr, input logic [1:0] idx, input logic [31:0] d);
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_address   <= idx;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [1:0] idx, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, idx, 32'h0000_0000);
    endtask

    // Notes the expected outcome, presents the axis state and issues the command in one cycle.
    task automatic cmd(input cesc_cmd_type c, input logic [11:0] s);
        logic [15:0] e;
        e    = exp_err(c, s);
        st_m = st_m | e;
        st  <= s;
        cmd_q.push_back((e == 16'h0000) ? {2'b11, c} : {2'b00, CMD_NOP});
        host.send(c);
    endtask

    // Command answers are watched at the falling edge, where registered values have settled.
    always @(negedge core_clk) begin
        if (cmd_done === 1'b1)
            chk_cmd({cmd_accepted, exec_valid, exec_code}, cmd_q.size() ? cmd_q.pop_front() : 6'h3f);
    end

    // Read data is taken at the rising edge that samples waitrequest low, as the master does.
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            chk_word(avs_readdata, rd_q.size() ? rd_q.pop_front() : 32'hdead_beef);
    end

    // A hang is cut short well beyond the roughly four hundred cycles the sequence needs.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        int          tries;
        logic [31:0] r;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        rd(CESC_STATUS_IDX, 32'h0000_0000);
        rd(CESC_MASK_IDX, 32'h0000_0000);
        bus(1'b1, CESC_MASK_IDX, 32'hffff_ffff);
        mask_m = CESC_IMPL_MASK;
        rd(CESC_MASK_IDX, {16'h0000, CESC_IMPL_MASK});
        bus(1'b1, 2'h3, 32'hffff_ffff);
        rd(2'h2, 32'h0000_0000);
        // Every code but CMD_NOP once with all state flags up and once with none, back to back.
        for (int k = 1; k < 16; k++) begin
            cmd(cesc_cmd_type'(k), 12'hfff);
            cmd(cesc_cmd_type'(k), 12'h000);
        end
        for (int k = 0; k < 300; k++) begin
            r = $random(seed);
            cmd(cesc_cmd_type'((r[3:0] == 4'h0) ? 4'h1 : r[3:0]), r[27:16]);
        end
        host.stop();
        @(posedge core_clk);
        @(negedge core_clk);
        chk_word({31'h0, irq}, {31'h0, |(st_m & mask_m)});
        @(posedge core_clk);
        rd(CESC_STATUS_IDX, {16'h0000, st_m});
        r = $random(seed);
        bus(1'b1, CESC_STATUS_IDX, r);
        st_m = st_m & ~r[15:0];
        rd(CESC_STATUS_IDX, {16'h0000, st_m});
        bus(1'b1, CESC_MASK_IDX, 32'h0000_0000);
        mask_m = 16'h0000;
        @(negedge core_clk);
        chk_word({31'h0, irq}, 32'h0000_0000);
        @(posedge core_clk);
        bus(1'b1, CESC_STATUS_IDX, 32'h0000_ffff);
        st_m = 16'h0000;
        rd(CESC_STATUS_IDX, 32'h0000_0000);
        // Buffer full for three offers, then free: three refusals and one acceptance.
        st <= 12'h800;
        st_m = 16'h8000;
        repeat (3) cmd_q.push_back({2'b00, CMD_NOP});
        cmd_q.push_back({2'b11, CMD_MOTION_DESC});
        fork
            host.resend(CMD_MOTION_DESC, tries);
            begin
                repeat (5) @(posedge core_clk);
                st <= 12'h000;
            end
        join
        chk_word(tries, 32'h0000_0004);
        rd(CESC_STATUS_IDX, 32'h0000_8000);
        // A faulty command offered while the clock enable is low must leave no trace.
        ce <= 1'b0;
        st <= 12'hfff;
        host.send(CMD_ARM_HOME);
        host.stop();
        ce <= 1'b1;
        rd(CESC_STATUS_IDX, 32'h0000_8000);
        repeat (2) @(posedge core_clk);
        // Every noted result must have been answered; a silent device would leave notes behind.
        chk_word(cmd_q.size() + rd_q.size(), 32'h0000_0000);
        report_and_stop();
    end
endmodule
